// File: design/fault_flag_map.svh
`ifndef FAULT_FLAG_MAP_SVH
`define FAULT_FLAG_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_FEATURE_ID 8'h00
`define OFS_CTRL 8'h04
`define OFS_RESUME 8'h08
`define OFS_EVT_STAT 8'h0c
`define OFS_EVT_VA_LO 8'h10
`define OFS_EVT_VA_HI 8'h14
`define OFS_EVT_IPA_LO 8'h18
`define OFS_EVT_IPA_HI 8'h1c
`define OFS_IRQ_STAT 8'h20
`define OFS_IRQ_MASK 8'h24

// ----------------------------------------------------------------
// field positions and encodings
// ----------------------------------------------------------------
`define CTRL_S1_STALL 0
`define CTRL_S2_STALL 1
`define CTRL_UPD_EN 2
`define RESUME_RETRY 0
`define RESUME_TERM 1
`define IRQ_ABORT 0
`define IRQ_STALL 1
`define IRQ_UPDATE 2
`define CAP_NONE 2'h0
`define CAP_AF_ONLY 2'h1
`define CAP_AF_DIRTY 2'h2
`define DESC_AF_BIT 10
`define DESC_WR_BIT 7
`define DESC_DBM_BIT 51

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET 3'h0
`define IRQ_MASK_RESET 3'h0

`endif

// File: design/fault_flag_pkg.sv
package fault_flag_pkg;

  // ----------------------------------------------------------------
  // fault report from the translation pipeline
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic translation;
    logic stage2;
    logic walk;
    logic [3:0] code;
    logic [63:0] va;
    logic [63:0] ipa;
  } fault_req_t;

  // ----------------------------------------------------------------
  // descriptor handed over for flag maintenance
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic long_fmt;
    logic leaf;
    logic write;
    logic stage2;
    logic ha_en;
    logic hd_en;
    logic [63:0] addr;
    logic [63:0] data;
  } desc_req_t;

  typedef struct packed {
    logic valid;
    logic access_fault;
    logic perm_fault;
    logic [63:0] data;
  } desc_res_t;

  typedef struct packed {
    logic valid;
    logic [63:0] addr;
    logic [63:0] expect_val;
    logic [63:0] swap_val;
  } cas_req_t;

  typedef enum logic [0:0] {UPD_IDLE, UPD_CAS} upd_state_t;

endpackage

// File: design/fault_flag_unit.sv
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "fault_flag_map.svh"
module fault_flag_unit
  import fault_flag_pkg::*;
#(
  parameter logic [1:0] HW_UPD_CAP = `CAP_AF_DIRTY
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire fault_flag_pkg::fault_req_t fault_i,
  output logic fault_ready,
  output logic xact_abort,
  output logic xact_stall,
  output logic xact_retry,
  output logic xact_term,
  input wire fault_flag_pkg::desc_req_t desc_i,
  output logic desc_ready,
  output fault_flag_pkg::desc_res_t desc_o,
  output fault_flag_pkg::cas_req_t mem_req,
  input wire logic mem_ack,
  input wire logic mem_ok,
  input wire logic [63:0] mem_rdata,
  output logic irq
);
  import fault_flag_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [2:0] ctrl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic evt_valid;
    logic evt_stage2;
    logic evt_stalled;
    logic [3:0] evt_code;
    logic [63:0] evt_va;
    logic [63:0] evt_ipa;
    logic fault_ready;
    logic abort;
    logic stall;
    logic retry;
    logic term;
    upd_state_t upd_st;
    desc_req_t upd_ctx;
    logic desc_ready;
    desc_res_t desc_res;
    cas_req_t cas;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ----------------------------------------------------------------
  // descriptor helpers
  // ----------------------------------------------------------------
  // stage 1 write permission is AP[2]==0, stage 2 is S2AP[1]==1
  function automatic logic is_writable(input logic [63:0] d, input logic s2);
    is_writable = s2 ? d[`DESC_WR_BIT] : ~d[`DESC_WR_BIT];
  endfunction

  function automatic logic af_upd_on(input desc_req_t c, input logic [2:0] ctl);
    af_upd_on = (HW_UPD_CAP != `CAP_NONE) && ctl[`CTRL_UPD_EN] && c.ha_en &&
                c.long_fmt;
  endfunction

  function automatic logic dirty_upd_on(input desc_req_t c, input logic [2:0] ctl);
    dirty_upd_on = (HW_UPD_CAP == `CAP_AF_DIRTY) && ctl[`CTRL_UPD_EN] && c.hd_en &&
                   c.long_fmt && c.leaf;
  endfunction

  // new descriptor value; AF is only ever set, a stage 1 dirty update clears bit 7 (AP[2])
  function automatic logic [63:0] calc_new(input desc_req_t c, input logic [63:0] d,
                                          input logic [2:0] ctl);
    logic [63:0] v;
    v = d;
    if (af_upd_on(c, ctl)) begin
      v[`DESC_AF_BIT] = 1'b1;
    end
    if (c.write && dirty_upd_on(c, ctl) && d[`DESC_DBM_BIT] && !is_writable(d, c.stage2)) begin
      v[`DESC_WR_BIT] = c.stage2;
      v[`DESC_AF_BIT] = 1'b1;
    end
    calc_new = v;
  endfunction

  function automatic desc_res_t finish(input desc_req_t c, input logic [63:0] v);
    desc_res_t r;
    r.valid = 1'b1;
    r.access_fault = ~v[`DESC_AF_BIT];
    r.perm_fault = c.write & ~is_writable(v, c.stage2);
    r.data = v;
    finish = r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic acc;
    logic [2:0] ev_set;
    logic [2:0] ev_clr;
    logic eff_s2;
    logic stall_cfg;
    logic [63:0] nv;
    acc = 1'b0;
    ev_set = 3'h0;
    ev_clr = 3'h0;
    eff_s2 = 1'b0;
    stall_cfg = 1'b0;
    nv = 64'h0;
    state_nxt = state_r;
    state_nxt.wb_ack = 1'b0;
    state_nxt.abort = 1'b0;
    state_nxt.retry = 1'b0;
    state_nxt.term = 1'b0;
    state_nxt.desc_res.valid = 1'b0;

    // bus slave: one wait state, unmapped reads return zero
    acc = wb_cyc_i & wb_stb_i & ~state_r.wb_ack;
    if (acc) begin
      state_nxt.wb_ack = 1'b1;
      case (wb_adr_i)
        `OFS_FEATURE_ID: state_nxt.wb_dat = {30'h0, HW_UPD_CAP};
        `OFS_CTRL: state_nxt.wb_dat = {29'h0, state_r.ctrl};
        `OFS_EVT_STAT: state_nxt.wb_dat = {24'h0, state_r.evt_code, 1'b0,
                                            state_r.evt_stalled, state_r.evt_stage2,
                                            state_r.evt_valid};
        `OFS_EVT_VA_LO: state_nxt.wb_dat = state_r.evt_va[31:0];
        `OFS_EVT_VA_HI: state_nxt.wb_dat = state_r.evt_va[63:32];
        `OFS_EVT_IPA_LO: state_nxt.wb_dat = state_r.evt_ipa[31:0];
        `OFS_EVT_IPA_HI: state_nxt.wb_dat = state_r.evt_ipa[63:32];
        `OFS_IRQ_STAT: state_nxt.wb_dat = {29'h0, state_r.irq_stat};
        `OFS_IRQ_MASK: state_nxt.wb_dat = {29'h0, state_r.irq_mask};
        default: state_nxt.wb_dat = 32'h0;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          `OFS_CTRL: state_nxt.ctrl = wb_dat_i[2:0];
          `OFS_IRQ_STAT: ev_clr = wb_dat_i[2:0];
          `OFS_IRQ_MASK: state_nxt.irq_mask = wb_dat_i[2:0];
          `OFS_RESUME: begin
            // a resume with no stall pending is ignored
            if (state_r.stall && wb_dat_i[`RESUME_RETRY]) begin
              state_nxt.stall = 1'b0;
              state_nxt.retry = 1'b1;
            end else if (state_r.stall && wb_dat_i[`RESUME_TERM]) begin
              state_nxt.stall = 1'b0;
              state_nxt.term = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // fault disposition
    if (fault_i.valid && state_r.fault_ready) begin
      eff_s2 = fault_i.stage2 | fault_i.walk;
      stall_cfg = eff_s2 ? state_r.ctrl[`CTRL_S2_STALL] : state_r.ctrl[`CTRL_S1_STALL];
      state_nxt.evt_valid = 1'b1;
      state_nxt.evt_stage2 = eff_s2;
      state_nxt.evt_code = fault_i.code;
      state_nxt.evt_va = fault_i.va;
      state_nxt.evt_ipa = eff_s2 ? fault_i.ipa : 64'h0;
      if (fault_i.translation && stall_cfg) begin
        state_nxt.stall = 1'b1;
        state_nxt.evt_stalled = 1'b1;
        ev_set[`IRQ_STALL] = 1'b1;
      end else begin
        state_nxt.abort = 1'b1;
        state_nxt.evt_stalled = 1'b0;
        ev_set[`IRQ_ABORT] = 1'b1;
      end
    end
    // one stall at a time; the pipeline holds off behind it
    state_nxt.fault_ready = ~state_nxt.stall;

    // hardware flag update
    case (state_r.upd_st)
      UPD_IDLE: begin
        if (desc_i.valid && state_r.desc_ready) begin
          nv = calc_new(desc_i, desc_i.data, state_r.ctrl);
          if (nv != desc_i.data) begin
            state_nxt.upd_st = UPD_CAS;
            state_nxt.upd_ctx = desc_i;
            state_nxt.desc_ready = 1'b0;
            state_nxt.cas.valid = 1'b1;
            state_nxt.cas.addr = desc_i.addr;
            state_nxt.cas.expect_val = desc_i.data;
            state_nxt.cas.swap_val = nv;
          end else begin
            state_nxt.desc_res = finish(desc_i, desc_i.data);
          end
        end
      end
      UPD_CAS: begin
        if (mem_ack) begin
          if (mem_ok) begin
            state_nxt.cas.valid = 1'b0;
            state_nxt.upd_st = UPD_IDLE;
            state_nxt.desc_ready = 1'b1;
            state_nxt.desc_res = finish(state_r.upd_ctx, state_r.cas.swap_val);
            ev_set[`IRQ_UPDATE] = 1'b1;
          end else begin
            // another agent changed it: recompute on the fresh value
            nv = calc_new(state_r.upd_ctx, mem_rdata, state_r.ctrl);
            if (nv != mem_rdata) begin
              state_nxt.cas.expect_val = mem_rdata;
              state_nxt.cas.swap_val = nv;
            end else begin
              state_nxt.cas.valid = 1'b0;
              state_nxt.upd_st = UPD_IDLE;
              state_nxt.desc_ready = 1'b1;
              state_nxt.desc_res = finish(state_r.upd_ctx, mem_rdata);
            end
          end
        end
      end
      default: begin
        state_nxt.upd_st = UPD_IDLE;
        state_nxt.cas.valid = 1'b0;
        state_nxt.desc_ready = 1'b1;
      end
    endcase

    // sticky status, set wins over write-one-to-clear
    state_nxt.irq_stat = (state_r.irq_stat & ~ev_clr) | ev_set;
    state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
      state_r.ctrl <= `CTRL_RESET;
      state_r.irq_mask <= `IRQ_MASK_RESET;
      state_r.fault_ready <= 1'b1;
      state_r.desc_ready <= 1'b1;
      state_r.upd_st <= UPD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = state_r.wb_dat;
  assign wb_ack_o = state_r.wb_ack;
  assign fault_ready = state_r.fault_ready;
  assign xact_abort = state_r.abort;
  assign xact_stall = state_r.stall;
  assign xact_retry = state_r.retry;
  assign xact_term = state_r.term;
  assign desc_ready = state_r.desc_ready;
  assign desc_o = state_r.desc_res;
  assign mem_req = state_r.cas;
  assign irq = state_r.irq;

endmodule // fault_flag_unit

// File: verif/fault_flag_checker.sv
`timescale 1ns/1ps
module fault_flag_checker
  import fault_flag_pkg::*;
#(
  parameter logic [1:0] HW_UPD_CAP = 2'h2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire fault_flag_pkg::fault_req_t fault_i,
  input wire logic fault_ready,
  input wire logic xact_abort,
  input wire logic xact_stall,
  input wire logic xact_retry,
  input wire logic xact_term,
  input wire fault_flag_pkg::desc_req_t desc_i,
  input wire logic desc_ready,
  input wire fault_flag_pkg::desc_res_t desc_o,
  input wire fault_flag_pkg::cas_req_t mem_req,
  input wire logic mem_ack
);
  // ----------------------------------------
  // port relations
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_cap_field: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
    && wb_adr_i == 8'h00 |=> wb_dat_o[1:0] == HW_UPD_CAP) else $error("cap wrong");
  a_other_abort: assert property (fault_i.valid && fault_ready && !fault_i.translation
    |=> xact_abort && !xact_stall) else $error("bad fault stalled");
  a_stall_holds: assert property (xact_stall |-> !fault_ready && !xact_abort)
    else $error("stall leaks");
  a_stall_ends: assert property ($fell(xact_stall) |-> xact_retry ^ xact_term)
    else $error("stall ended alone");
  a_fmt_only: assert property (desc_i.valid && desc_ready && !desc_i.long_fmt
    |=> desc_o.valid && !mem_req.valid) else $error("short format updated");
  a_enable_gate: assert property (desc_i.valid && desc_ready && !desc_i.ha_en
    && !desc_i.hd_en |=> !mem_req.valid) else $error("update not enabled");
  a_af_kept: assert property (mem_req.valid |-> mem_req.swap_val[10])
    else $error("access flag cleared");
  a_cas_stable: assert property (mem_req.valid && !mem_ack |=> mem_req.valid
    && $stable(mem_req.addr) && $stable(mem_req.expect_val)) else $error("swap dropped");
endmodule // fault_flag_checker

bind fault_flag_unit fault_flag_checker #(.HW_UPD_CAP(HW_UPD_CAP)) fault_flag_checker_inst (
  .clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .fault_i,
  .fault_ready, .xact_abort, .xact_stall, .xact_retry, .xact_term, .desc_i, .desc_ready,
  .desc_o, .mem_req, .mem_ack);

// File: verif/cas_memory.sv
`timescale 1ns/1ps
module cas_memory
  import fault_flag_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire fault_flag_pkg::cas_req_t mem_req,
  output logic mem_ack,
  output logic mem_ok,
  output logic [63:0] mem_rdata
);
  // ----------------------------------------
  // one shared table word
  // ----------------------------------------
  // word_r is also written by the bench, acting as a second agent
  logic [63:0] word_r;
  logic [1:0] wait_r;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_ack <= 1'b0;
      mem_ok <= 1'b0;
      wait_r <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req.valid && !mem_ack) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == 2'h2) begin
          wait_r <= 2'h0;
          mem_ack <= 1'b1;
          mem_ok <= mem_req.expect_val === word_r;
          mem_rdata <= word_r;
          if (mem_req.expect_val === word_r) word_r <= mem_req.swap_val;
        end
      end else begin
        // stale data must not look valid
        mem_rdata <= ~mem_rdata;
      end
    end
  end
endmodule // cas_memory

// File: verif/two_stage_fault_and_flag_update_test.sv
`timescale 1ns/1ps
`include "fault_flag_map.svh"
module two_stage_fault_and_flag_update_test;
  import fault_flag_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, fault_ready, xact_abort, xact_stall, xact_retry, xact_term;
  logic desc_ready, mem_ack, mem_ok, irq, ab, st;
  logic [63:0] mem_rdata;
  fault_req_t fault_i = '0;
  desc_req_t desc_i = '0;
  desc_res_t desc_o;
  cas_req_t mem_req;
  int fails = 0;
  int total_checks = 0;
  int retries = 0;
  int terms = 0;
  always #5 clk = ~clk;
  // resume pulses last one cycle, so count them as they pass
  always @(posedge clk) begin
    if (xact_retry === 1'b1) retries++;
    if (xact_term === 1'b1) terms++;
  end
  fault_flag_unit fault_flag_unit_inst (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fault_i, .fault_ready, .xact_abort,
    .xact_stall, .xact_retry, .xact_term, .desc_i, .desc_ready, .desc_o, .mem_req, .mem_ack,
    .mem_ok, .mem_rdata, .irq);
  cas_memory cas_memory_inst (.clk, .arst_n, .mem_req, .mem_ack, .mem_ok, .mem_rdata);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic give_up;
    fails++;
    final_report();
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
    if (n == 20) give_up();
  endtask
  task automatic flt(input logic tr, input logic s2, input logic wk);
    fault_i <= '{1'b1, tr, s2, wk, 4'h5, 64'h0123_4567_89ab_cdef, 64'h0000_00fe_dcba_9870};
    @(posedge clk);
    fault_i.valid <= 1'b0;
    #1;
    ab = xact_abort;
    st = xact_stall;
    @(posedge clk);
  endtask
  task automatic dcase(input logic lf, input logic wr, input logic ha, input logic [63:0] d,
      input logic [63:0] m, input logic [63:0] ed, input logic [1:0] ef, input logic s2);
    int n;
    n = 0;
    cas_memory_inst.word_r = m;
    desc_i <= '{1'b1, lf, 1'b1, wr, s2, ha, ha, 64'h1000, d};
    @(posedge clk);
    desc_i.valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (desc_o.valid !== 1'b1 && n < 40);
    chk("desc_data", ed, desc_o.data);
    chk("desc_fault", ef, {desc_o.access_fault, desc_o.perm_fault});
    chk("mem_word", (ed !== d) ? ed : m, cas_memory_inst.word_r);
    @(posedge clk);
    if (n == 40) give_up();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_misc;
    wb(1'b1, `OFS_FEATURE_ID, 32'h0);
    wb(1'b0, `OFS_FEATURE_ID, 32'h0);
    chk("cap", `CAP_AF_DIRTY, q[1:0]);
    wb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl_reset", 32'h0, q);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, `OFS_CTRL, 32'h3);
    flt(1'b0, 1'b0, 1'b0);
    chk("other_fault", 2'b10, {ab, st});
    wb(1'b1, `OFS_CTRL, 32'h2);
    flt(1'b1, 1'b0, 1'b1);
    chk("walk_fault", 2'b01, {ab, st});
    wb(1'b1, `OFS_RESUME, 32'h1);
    // irq is registered in the same cycle as the mask write, so the extra cycle is only margin
    wb(1'b1, `OFS_IRQ_MASK, 32'h1);
    @(posedge clk);
    chk("irq_on", 1'b1, irq);
    wb(1'b1, `OFS_IRQ_STAT, 32'h1);
    @(posedge clk);
    chk("irq_off", 1'b0, irq);
  endtask
  task automatic t_faults;
    logic s;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 2; k++) begin
        s = c[k];
        wb(1'b1, `OFS_CTRL, c);
        flt(1'b1, k[0], 1'b0);
        chk("stall", s, st);
        chk("abort", !s, ab);
        wb(1'b0, `OFS_EVT_IPA_LO, 32'h0);
        chk("ipa_lo", k ? 32'hdcba_9870 : 32'h0, q);
        wb(1'b0, `OFS_EVT_VA_HI, 32'h0);
        chk("va_hi", 32'h0123_4567, q);
        if (s) wb(1'b1, `OFS_RESUME, k ? 32'h1 : 32'h2);
        chk("ready", 1'b1, fault_ready);
      end
    end
    @(posedge clk);
    chk("retries", 3, retries);
    chk("terms", 2, terms);
  endtask
  task automatic t_desc;
    wb(1'b1, `OFS_CTRL, 32'h4);
    dcase(1'b1, 1'b0, 1'b1, 64'h3, 64'h7, 64'h407, 2'b00, 1'b0);
    dcase(1'b0, 1'b0, 1'b1, 64'h3, 64'h3, 64'h3, 2'b10, 1'b0);
    dcase(1'b1, 1'b0, 1'b0, 64'h3, 64'h3, 64'h3, 2'b10, 1'b0);
    dcase(1'b1, 1'b1, 1'b1, 64'h8_0000_0000_0480, 64'h8_0000_0000_0480,
      64'h8_0000_0000_0400, 2'b00, 1'b0);
    dcase(1'b1, 1'b1, 1'b1, 64'h480, 64'h480, 64'h480, 2'b01, 1'b0);
    // stage 2 grants write by setting the permission bit instead
    dcase(1'b1, 1'b1, 1'b1, 64'h8_0000_0000_0400, 64'h8_0000_0000_0400,
      64'h8_0000_0000_0480, 2'b00, 1'b1);
    wb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h7, q);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_misc();
    t_faults();
    t_desc();
    final_report();
  end
endmodule // two_stage_fault_and_flag_update_test
